// ==== verilog/ssrp_pkg.sv ====
// Shared constants, register offsets and helpers of the serial register port
package ssrp_pkg;
    // Core clock and host hold-off after a reset
    localparam int unsigned CLK_MHZ = 10;
    localparam int unsigned HOLDOFF_US = 100;
    localparam int unsigned HOLDOFF_CYC = HOLDOFF_US * CLK_MHZ;
    localparam logic [9:0] HOLDOFF_CNT = 10'(HOLDOFF_CYC);
    // Host serial clock: each half period lasts HALF_LAST+1 core cycles
    localparam logic [2:0] HALF_LAST = 3'h3;

    // Device-side address map
    localparam logic [13:0] ORDER_ADDR = 14'h3fff;
    localparam logic [13:0] ABORT_ADDR = 14'h3ffe;
    localparam logic [13:0] MASTER_CONFIG_ONE_ADDR = 14'h0032;
    localparam int ORDER_LO_BIT = 3;
    localparam int ORDER_HI_BIT = 4;
    localparam int SRST_BIT = 7;
    localparam int ABORT_BIT = 0;
    localparam logic [1:0] ORDER_RST = 2'h0;
    // First byte of each two-byte field; the second sits at base+1
    localparam logic [13:0] PAIR_BASE [0:3] = '{14'h003c, 14'h0041, 14'h0046, 14'h0070};

    // Frame bit counts
    localparam logic [4:0] HDR_LAST = 5'h0f;
    localparam logic [4:0] DATA_FIRST = 5'h10;
    localparam logic [4:0] BYTE_LAST = 5'h17;
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam logic [4:0] DATA_BITS = 5'h08;

    // Host Wishbone register offsets (byte addresses)
    localparam logic [4:0] HR_CTRL = 5'h00;
    localparam logic [4:0] HR_ADDR = 5'h04;
    localparam logic [4:0] HR_TXD = 5'h08;
    localparam logic [4:0] HR_RXD = 5'h0c;
    localparam logic [4:0] HR_STAT = 5'h10;
    // Host control register fields
    localparam int C_GO = 0;
    localparam int C_RW = 1;
    localparam int C_BURST = 2;
    localparam int C_CONT = 3;
    localparam int C_KEEP = 4;
    localparam int C_LSB = 5;
    localparam int C_CPHA = 6;
    localparam int C_HOLD = 7;

    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_SEL = 3'h1,
        H_PH0 = 3'h2,
        H_PH1 = 3'h3,
        H_END = 3'h4,
        H_GAP = 3'h5
    } ssrp_hsm_t;

    function automatic logic [13:0] rev14(input logic [13:0] v);
        logic [13:0] r;
        r = '0;
        for (int i = 0; i < 14; i++) begin
            r[i] = v[13 - i];
        end
        return r;
    endfunction : rev14

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction : rev8
endpackage : ssrp_pkg

// ==== verilog/ssrp_if.sv ====
// Serial link between the register port device and its master
`timescale 1ns/10ps
`default_nettype none
interface ssrp_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
    logic cpha;
    // Set by the bench when data in and data out share one wire
    logic tied;
    logic line;
    logic sdi_dev;

    // Resolved level of the data-out wire, pulled up when nobody drives
    assign line = miso_oe ? miso : (mosi_oe && tied) ? mosi : 1'b1;
    assign sdi_dev = tied ? line : mosi;

    modport dev (input cs_n, input sclk, input sdi_dev, input cpha,
                 output miso, output miso_oe);
    modport host (output cs_n, output sclk, output mosi, output mosi_oe,
                  output cpha, input line);
endinterface : ssrp_if
`default_nettype wire

// ==== verilog/ssrp_dev.sv ====
// Serial register port, device end: SPI slave giving byte access to registers
//
// Overview of operation
// RULE1 - Slave only; master starts frames, drives clock
// RULE2 - Data out released except while returning reads
// RULE3 - Bits 3/4 at 3FFFh pick LSB-first order
// RULE4 - Master idles clock low, pulses per bit
// RULE5 - Phase 0: capture on rise, shift on fall
// RULE6 - Phase 1: capture on fall, shift on rise
// RULE7 - Clock toggling while deselected is harmless
// RULE8 - Master drives dedicated low-active select
// RULE9 - Sixteen-bit header: direction, address, burst
// RULE10 - Direction 1 reads; burst 1 bursts
// RULE11 - LSB-first mode reverses the address bits
// RULE12 - Single write stores one byte
// RULE13 - Single read returns one byte
// RULE14 - Burst write stores, increments, wraps address
// RULE15 - Burst read prefetches, increments, wraps address
// RULE16 - Select rising resets the serial logic
// RULE17 - Partial data byte is never written
// RULE18 - Master releases shared wire during reads
// RULE19 - Reset returns everything to defaults
// RULE20 - Soft reset spares serial logic and itself
// RULE21 - Master waits 100 us after reset
// RULE22 - Master runs tuning writes after reset; the bench issues none and starts its tests right after the hold-off
// RULE23 - Interrupted pair write drops, flags abort
// RULE24 - Read data follows header without dummy bits
`timescale 1ns/10ps
`default_nettype none
module ssrp_dev (
    input wire logic clk_i,
    input wire logic rst_i,
    ssrp_if.dev link,
    output logic [13:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_we_o,
    output logic reg_re_o,
    input wire logic [7:0] reg_rdata_i,
    output logic soft_rst_o,
    output logic multi_register_abort_o
);
    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] clk_s;
        logic [1:0] din_s;
        logic [1:0] pha_s;
        logic [4:0] cnt;
        logic [15:0] sh;
        logic hdr;
        logic rw;
        logic burst;
        logic fin;
        logic [13:0] addr;
        logic [7:0] tx;
        logic sdo;
        logic oe;
        logic [1:0] order;
        logic abort;
        logic srst;
        logic st_v;
        logic [13:0] st_a;
        logic [7:0] st_d;
        logic w2_v;
        logic [13:0] w2_a;
        logic [7:0] w2_d;
        logic [13:0] ra;
        logic [7:0] wd;
        logic we;
        logic re;
    } ssrp_dev_t;

    ssrp_dev_t q;
    ssrp_dev_t n;

    logic sel;
    logic rise;
    logic fall;
    logic cap;
    logic shf;
    logic lsb;
    logic din;
    logic [13:0] hdr_a;
    logic [13:0] nxt_a;
    logic [7:0] rx_b;
    logic wr_go;
    logic rd_go;
    logic [13:0] acc_a;
    logic [2:0] pi;
    logic [2:0] si;
    logic mate;
    logic abort_ev;

    // Which two-byte field an address belongs to: {hit, field index}
    function automatic logic [2:0] pair_idx(input logic [13:0] a);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < 4; i++) begin
            if (a == ssrp_pkg::PAIR_BASE[i] || a == ssrp_pkg::PAIR_BASE[i] + 14'h0001) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction : pair_idx

    // Edge and mode decode from the synchronised link pins
    assign sel = ~q.cs_s[1];
    assign rise = q.clk_s[1] & ~q.clk_s[2];
    assign fall = ~q.clk_s[1] & q.clk_s[2];
    assign cap = q.pha_s[1] ? fall : rise; // RULE5 RULE6
    assign shf = q.pha_s[1] ? rise : fall; // RULE5 RULE6
    assign lsb = |q.order; // RULE3
    assign din = q.din_s[1];
    assign hdr_a = lsb ? ssrp_pkg::rev14(q.sh[13:0]) : q.sh[13:0]; // RULE11
    assign rx_b = lsb ? ssrp_pkg::rev8({q.sh[6:0], din}) : {q.sh[6:0], din};
    assign nxt_a = q.addr + 14'h0001; // RULE14 RULE15

    // All next-state logic; pins pass two flops before anything reads them
    always_comb begin
        n = q;
        n.we = 1'b0;
        n.re = 1'b0;
        wr_go = 1'b0;
        rd_go = 1'b0;
        acc_a = q.addr;
        n.cs_s = {q.cs_s[1:0], link.cs_n};
        n.clk_s = {q.clk_s[1:0], link.sclk};
        n.din_s = {q.din_s[0], link.sdi_dev};
        n.pha_s = {q.pha_s[0], link.cpha};

        // Second byte of a committed pair goes out one cycle after the first
        if (q.w2_v) begin
            n.we = 1'b1;
            n.ra = q.w2_a;
            n.wd = q.w2_d;
            n.w2_v = 1'b0;
        end
        // Register file answers in the cycle of the read strobe
        if (q.re) begin
            n.tx = reg_rdata_i;
        end

        // Serial engine; edges while deselected are never counted
        if (!sel) begin
            n.cnt = 5'h00; // RULE16 RULE7
            n.hdr = 1'b0;
            n.fin = 1'b0;
            n.oe = 1'b0; // RULE2
        end else if (cap) begin
            n.sh = {q.sh[14:0], din}; // RULE1
            n.cnt = (q.cnt == ssrp_pkg::BYTE_LAST) ? ssrp_pkg::DATA_FIRST : q.cnt + 5'h01;
            if (q.cnt == ssrp_pkg::HDR_LAST) begin
                // Header: direction first, address, burst last
                n.hdr = 1'b1; // RULE9
                n.rw = q.sh[14]; // RULE10
                n.burst = din; // RULE10
                n.addr = hdr_a;
                rd_go = q.sh[14]; // RULE13
                acc_a = hdr_a;
            end else if (q.cnt == ssrp_pkg::BYTE_LAST && q.hdr && !q.fin) begin
                // Only the edge that takes a byte's last bit commits it
                n.fin = ~q.burst; // RULE12 RULE13
                if (q.burst) begin
                    n.addr = nxt_a; // RULE14 RULE15
                end
                wr_go = ~q.rw; // RULE17 RULE12
                rd_go = q.rw & q.burst; // RULE15
                acc_a = q.rw ? nxt_a : q.addr;
            end
        end else if (shf && q.hdr && q.rw) begin
            // First shift edge after the header already carries data
            n.oe = ~q.fin; // RULE2 RULE24
            n.sdo = lsb ? q.tx[q.cnt[2:0]] : q.tx[3'h7 - q.cnt[2:0]]; // RULE24 RULE3
        end

        // Two-byte fields are staged until both halves arrive back to back
        pi = pair_idx(acc_a);
        si = pair_idx(q.st_a);
        mate = wr_go & q.st_v & pi[2] & (pi == si) & (acc_a != q.st_a);
        abort_ev = (wr_go | rd_go) & q.st_v & ~mate; // RULE23
        if (abort_ev) begin
            n.st_v = 1'b0; // RULE23
        end

        if (wr_go) begin
            if (acc_a == ssrp_pkg::ORDER_ADDR) begin
                n.order = {rx_b[ssrp_pkg::ORDER_HI_BIT], rx_b[ssrp_pkg::ORDER_LO_BIT]}; // RULE3
            end else if (acc_a == ssrp_pkg::ABORT_ADDR) begin
                if (rx_b[ssrp_pkg::ABORT_BIT]) begin
                    n.abort = 1'b0;
                end
            end else if (mate) begin
                n.we = 1'b1;
                n.ra = q.st_a;
                n.wd = q.st_d;
                n.w2_v = 1'b1;
                n.w2_a = acc_a;
                n.w2_d = rx_b;
                n.st_v = 1'b0;
            end else if (pi[2]) begin
                n.st_v = 1'b1;
                n.st_a = acc_a;
                n.st_d = rx_b;
            end else begin
                n.we = 1'b1;
                n.ra = acc_a;
                n.wd = rx_b;
                if (acc_a == ssrp_pkg::MASTER_CONFIG_ONE_ADDR) begin
                    n.srst = rx_b[ssrp_pkg::SRST_BIT];
                end
            end
        end

        // Local registers answer at once; the rest through the read strobe
        if (rd_go) begin
            if (acc_a == ssrp_pkg::ORDER_ADDR) begin
                n.tx = 8'h00;
                n.tx[ssrp_pkg::ORDER_HI_BIT] = q.order[1];
                n.tx[ssrp_pkg::ORDER_LO_BIT] = q.order[0];
            end else if (acc_a == ssrp_pkg::ABORT_ADDR) begin
                n.tx = 8'h00;
                n.tx[ssrp_pkg::ABORT_BIT] = q.abort;
            end else begin
                n.re = 1'b1;
                n.ra = acc_a;
            end
        end

        // Set after clear, so a new abort is never lost to a clearing write
        if (abort_ev) begin
            n.abort = 1'b1; // RULE23
        end
        // Soft reset clears the core state but keeps the serial engine
        if (q.srst) begin
            n.abort = 1'b0; // RULE20
            n.st_v = 1'b0;
            n.w2_v = 1'b0;
        end

        // Pin reset: everything to defaults, select seen as idle
        if (rst_i) begin
            n = '0; // RULE19
            n.cs_s = 3'h7;
            n.order = ssrp_pkg::ORDER_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        q <= n;
    end

    // Outputs come straight from the state flops
    assign link.miso = q.sdo;
    assign link.miso_oe = q.oe;
    assign reg_addr_o = q.ra;
    assign reg_wdata_o = q.wd;
    assign reg_we_o = q.we;
    assign reg_re_o = q.re;
    assign soft_rst_o = q.srst; // RULE20
    assign multi_register_abort_o = q.abort;
endmodule : ssrp_dev
`default_nettype wire

// ==== verilog/ssrp_host.sv ====
// Serial register port, master end: Wishbone-controlled SPI frame engine
`timescale 1ns/10ps
`default_nettype none
module ssrp_host (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    ssrp_if.host link
);
    typedef struct packed {
        ssrp_pkg::ssrp_hsm_t st;
        logic [2:0] tm;
        logic [4:0] left;
        logic [23:0] sh;
        logic [7:0] rx;
        logic [1:0] mi_s;
        logic cs_n;
        logic sclk;
        logic mosi;
        logic moe;
        logic rw;
        logic burst;
        logic keep;
        logic lsb;
        logic cpha;
        logic [13:0] addr;
        logic [7:0] txd;
        logic [7:0] rxd;
        logic [9:0] hold;
        logic ack;
        logic [31:0] dat;
    } ssrp_hst_t;

    ssrp_hst_t q;
    ssrp_hst_t n;
    logic req;
    logic tm_end;
    logic to_ph0;
    logic busy;
    logic [7:0] rx_new;
    logic [7:0] d8;

    assign req = wb_cyc_i & wb_stb_i & ~q.ack;
    assign tm_end = (q.tm == ssrp_pkg::HALF_LAST);
    assign busy = (q.st != ssrp_pkg::H_IDLE);
    assign rx_new = {q.rx[6:0], q.mi_s[1]};
    assign d8 = wb_dat_i[7:0];

    always_comb begin
        n = q;
        to_ph0 = 1'b0;
        n.tm = tm_end ? 3'h0 : q.tm + 3'h1;
        n.mi_s = {q.mi_s[0], link.line};
        // Hold-off after reset before any frame may start
        if (q.hold != 10'h000) begin
            n.hold = q.hold - 10'h001; // RULE21
        end

        // Wishbone slave: answer one cycle after the request, for one cycle
        n.ack = req;
        if (req && wb_we_i) begin
            if (wb_adr_i == ssrp_pkg::HR_CTRL && wb_sel_i[0]) begin
                if (d8[ssrp_pkg::C_HOLD]) begin
                    n.hold = ssrp_pkg::HOLDOFF_CNT; // RULE21
                end else if (d8[ssrp_pkg::C_GO] && !busy && q.hold == 10'h000) begin
                    n.rw = d8[ssrp_pkg::C_RW];
                    n.burst = d8[ssrp_pkg::C_BURST];
                    n.keep = d8[ssrp_pkg::C_KEEP];
                    n.lsb = d8[ssrp_pkg::C_LSB];
                    n.cpha = d8[ssrp_pkg::C_CPHA];
                    n.tm = 3'h0;
                    n.cs_n = 1'b0; // RULE8
                    if (d8[ssrp_pkg::C_CONT]) begin
                        n.sh = {(d8[ssrp_pkg::C_LSB] ? ssrp_pkg::rev8(q.txd) : q.txd), 16'h0000};
                        n.left = ssrp_pkg::DATA_BITS;
                    end else begin
                        // Header then one byte; read bytes shift in meanwhile
                        n.sh = {d8[ssrp_pkg::C_RW],
                                (d8[ssrp_pkg::C_LSB] ? ssrp_pkg::rev14(q.addr) : q.addr),
                                d8[ssrp_pkg::C_BURST],
                                (d8[ssrp_pkg::C_LSB] ? ssrp_pkg::rev8(q.txd) : q.txd)}; // RULE9
                        n.left = ssrp_pkg::FRAME_BITS;
                    end
                    if (q.cs_n) begin
                        n.st = ssrp_pkg::H_SEL;
                    end else begin
                        to_ph0 = 1'b1;
                    end
                end
            end
            if (wb_adr_i == ssrp_pkg::HR_ADDR && wb_sel_i[0]) begin
                n.addr[7:0] = d8;
            end
            if (wb_adr_i == ssrp_pkg::HR_ADDR && wb_sel_i[1]) begin
                n.addr[13:8] = wb_dat_i[13:8];
            end
            if (wb_adr_i == ssrp_pkg::HR_TXD && wb_sel_i[0]) begin
                n.txd = d8;
            end
        end
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                ssrp_pkg::HR_CTRL: n.dat = {25'h0, q.cpha, q.lsb, q.keep, 1'b0, q.burst, q.rw, 1'b0};
                ssrp_pkg::HR_ADDR: n.dat = {18'h0, q.addr};
                ssrp_pkg::HR_TXD: n.dat = {24'h0, q.txd};
                ssrp_pkg::HR_RXD: n.dat = {24'h0, q.rxd};
                ssrp_pkg::HR_STAT: n.dat = {29'h0, ~q.cs_n, q.hold == 10'h000, busy};
                default: n.dat = 32'h0;
            endcase
        end

        // Frame engine; clock idles low between bits and frames
        case (q.st)
            ssrp_pkg::H_IDLE: begin
                n.sclk = 1'b0; // RULE4
            end
            ssrp_pkg::H_SEL: begin
                if (tm_end) begin
                    to_ph0 = 1'b1;
                end
            end
            ssrp_pkg::H_PH0: begin
                if (tm_end) begin
                    n.st = ssrp_pkg::H_PH1;
                    n.sclk = ~q.cpha; // RULE4
                end
            end
            ssrp_pkg::H_PH1: begin
                if (tm_end) begin
                    // Sample late in the bit: the synchroniser adds two cycles
                    n.rx = rx_new;
                    n.sh = {q.sh[22:0], 1'b0};
                    n.left = q.left - 5'h01;
                    if (q.left == 5'h01) begin
                        n.st = ssrp_pkg::H_END;
                        n.sclk = 1'b0;
                        n.moe = 1'b0;
                        n.rxd = q.lsb ? ssrp_pkg::rev8(rx_new) : rx_new; // RULE13
                    end else begin
                        to_ph0 = 1'b1;
                    end
                end
            end
            ssrp_pkg::H_END: begin
                if (tm_end) begin
                    if (q.keep) begin
                        n.st = ssrp_pkg::H_IDLE; // RULE14 RULE15
                    end else begin
                        n.cs_n = 1'b1; // RULE12 RULE13
                        n.st = ssrp_pkg::H_GAP;
                    end
                end
            end
            ssrp_pkg::H_GAP: begin
                if (tm_end) begin
                    n.st = ssrp_pkg::H_IDLE;
                end
            end
            default: n.st = ssrp_pkg::H_IDLE;
        endcase

        // Start of a bit: leading half, data out, wire released for reads
        if (to_ph0) begin
            n.st = ssrp_pkg::H_PH0;
            n.sclk = n.cpha; // RULE1
            n.mosi = n.sh[23];
            n.moe = ~(n.rw & (n.left <= ssrp_pkg::DATA_BITS)); // RULE18
        end

        if (rst_i) begin
            n = '0;
            n.cs_n = 1'b1;
            n.hold = ssrp_pkg::HOLDOFF_CNT; // RULE21
        end
    end

    always_ff @(posedge clk_i) begin
        q <= n;
    end

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.dat;
    assign link.cs_n = q.cs_n;
    assign link.sclk = q.sclk;
    assign link.mosi = q.mosi;
    assign link.mosi_oe = q.moe;
    assign link.cpha = q.cpha;
endmodule : ssrp_host
`default_nettype wire

// ==== tb/ssrp_props.sv ====
// Link checker for the serial register port, watching both ends at once
`timescale 1ns/10ps
`default_nettype none
module ssrp_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic mosi_oe,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic cpha
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic sclk_q;
    logic [7:0] rise_q;
    // Raw clock rises since select; saturates so long bursts cannot wrap
    always_ff @(posedge clk_i) begin
        sclk_q <= sclk;
        if (rst_i || cs_n) begin
            rise_q <= 8'h00;
        end else if (sclk && !sclk_q && rise_q != 8'hff) begin
            rise_q <= rise_q + 8'h01;
        end
    end
    property p_idle_low; cs_n |-> !sclk; endproperty
    a_idle_low: assert property (p_idle_low) else $error("clock high while idle");
    property p_sel_setup; $fell(cs_n) |-> !sclk [*4]; endproperty
    a_sel_setup: assert property (p_sel_setup) else $error("clock too soon");
    property p_high_width; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
    a_high_width: assert property (p_high_width) else $error("bad clock pulse");
    property p_release; cs_n [*5] |-> !miso_oe; endproperty
    a_release: assert property (p_release) else $error("data out driven");
    property p_no_clash; miso_oe |-> !mosi_oe; endproperty
    a_no_clash: assert property (p_no_clash) else $error("both ends drive");
    property p_shift_lead;
        !cpha && miso_oe && $past(miso_oe) && $changed(miso) |-> !sclk;
    endproperty
    a_shift_lead: assert property (p_shift_lead) else $error("shift off edge");
    property p_shift_trail;
        cpha && miso_oe && $past(miso_oe) && $changed(miso) |-> sclk;
    endproperty
    a_shift_trail: assert property (p_shift_trail) else $error("shift off edge");
    property p_turn; $rose(miso_oe) |-> rise_q == (cpha ? 8'h11 : 8'h10); endproperty
    a_turn: assert property (p_turn) else $error("read data misplaced");
    property p_hold_in; !cpha && sclk && mosi_oe |-> $stable(mosi); endproperty
    a_hold_in: assert property (p_hold_in) else $error("data in moved");
endmodule : ssrp_props
`default_nettype wire

// ==== tb/testbench.sv ====
// Bench joining host and device ends of the serial register port
`timescale 1ns/10ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic cpha;
        logic tied;
        logic lsb;
        logic [13:0] a;
        logic [7:0] d;
    } ssrp_row_t;
    // Single accesses over both phases, shared wire and both bit orders
    localparam ssrp_row_t ROWS [0:4] = '{
        '{1'h0, 1'h0, 1'h0, 14'h0123, 8'h5a},
        '{1'h1, 1'h0, 1'h0, 14'h2a81, 8'hc3},
        '{1'h0, 1'h1, 1'h0, 14'h1042, 8'h96},
        '{1'h1, 1'h1, 1'h1, 14'h0507, 8'h3a},
        '{1'h0, 1'h0, 1'h1, 14'h3e19, 8'he1}};
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic rst_h = 1'h1;
    logic any_rst;
    logic wb_cyc = 1'h0;
    logic wb_stb = 1'h0;
    logic wb_we = 1'h0;
    logic [4:0] wb_adr = 5'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_q;
    logic wb_ack;
    logic [13:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_we;
    logic reg_re;
    logic [7:0] reg_rdata;
    logic soft_rst;
    logic mra;
    logic [7:0] mem [0:255];
    logic [13:0] last_a = 14'h0;
    int wcnt = 0;
    int wsave;
    int miscompares = 0;
    int total_checks = 0;
    logic cpha_v = 1'h0;
    logic lsb_v = 1'h0;
    logic [31:0] rx;
    ssrp_if link ();
    assign any_rst = rst_i | rst_h;
    assign reg_rdata = reg_re ? mem[reg_addr[7:0]] : 8'h00;
    initial forever #50 clk_i = ~clk_i;
    // Register file behind the device; remembers the last write for checks
    always @(posedge clk_i) begin
        if (reg_we === 1'h1) begin
            mem[reg_addr[7:0]] <= reg_wdata;
            last_a <= reg_addr;
            wcnt <= wcnt + 1;
        end
    end
    ssrp_host i_ssrp_host (.clk_i(clk_i), .rst_i(rst_h), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_q), .wb_ack_o(wb_ack), .link(link));
    ssrp_dev i_ssrp_dev (.clk_i(clk_i), .rst_i(rst_i), .link(link), .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata), .reg_we_o(reg_we), .reg_re_o(reg_re), .reg_rdata_i(reg_rdata),
        .soft_rst_o(soft_rst), .multi_register_abort_o(mra));
    ssrp_props i_ssrp_props (.clk_i(clk_i), .rst_i(any_rst), .cs_n(link.cs_n),
        .sclk(link.sclk), .mosi(link.mosi), .mosi_oe(link.mosi_oe), .miso(link.miso),
        .miso_oe(link.miso_oe), .cpha(link.cpha));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    // One classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= w;
        wb_sel <= 4'hf;
        wb_adr <= a;
        wb_dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'h1 && n < 20);
        rx = wb_q;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        if (n >= 20) chk(32'h0, 32'h1);
    endtask : wb
    task automatic hold_off();
        int n;
        n = 0;
        wb(1'h0, ssrp_pkg::HR_STAT, 32'h0);
        chk({31'h0, rx[1]}, 32'h0);
        do begin
            wb(1'h0, ssrp_pkg::HR_STAT, 32'h0);
            n++;
        end while (rx[1] !== 1'h1 && n < 600);
        chk({31'h0, rx[1]}, 32'h1);
    endtask : hold_off
    // Control bits: 02 read, 04 burst, 08 continue, 10 keep selected
    task automatic start(input logic [7:0] ctl, input logic [13:0] a, input logic [7:0] d);
        wb(1'h1, ssrp_pkg::HR_ADDR, {18'h0, a});
        wb(1'h1, ssrp_pkg::HR_TXD, {24'h0, d});
        wb(1'h1, ssrp_pkg::HR_CTRL, {24'h0, ctl | {1'h0, cpha_v, lsb_v, 5'h01}});
    endtask : start
    task automatic xfer(input logic [7:0] ctl, input logic [13:0] a, input logic [7:0] d);
        int n;
        n = 0;
        start(ctl, a, d);
        do begin
            wb(1'h0, ssrp_pkg::HR_STAT, 32'h0);
            n++;
        end while (rx[0] !== 1'h0 && n < 300);
        if (n >= 300) chk(32'h0, 32'h1);
        wb(1'h0, ssrp_pkg::HR_RXD, 32'h0);
    endtask : xfer
    task automatic set_order(input logic l);
        xfer(8'h00, ssrp_pkg::ORDER_ADDR, l ? 8'h08 : 8'h00);
        lsb_v = l;
    endtask : set_order
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        link.tied = 1'h0;
        repeat (5) @(posedge clk_i);
        chk({27'h0, mra, soft_rst, link.miso_oe, link.cs_n, link.sclk}, 32'h2);
        rst_i <= 1'h0;
        rst_h <= 1'h0;
        hold_off();
        foreach (ROWS[i]) begin
            link.tied <= ROWS[i].tied;
            cpha_v = ROWS[i].cpha;
            if (ROWS[i].lsb !== lsb_v) set_order(ROWS[i].lsb);
            xfer(8'h00, ROWS[i].a, ROWS[i].d);
            chk({18'h0, last_a}, {18'h0, ROWS[i].a});
            chk({24'h0, mem[ROWS[i].a[7:0]]}, {24'h0, ROWS[i].d});
            xfer(8'h02, ROWS[i].a, 8'h00);
            chk(rx, {24'h0, ROWS[i].d});
            $display("row %0d done", i);
        end
        set_order(1'h0);
        // Bursts across the top of the address space, one continuation byte each
        xfer(8'h14, ssrp_pkg::ORDER_ADDR, 8'h00);
        xfer(8'h08, 14'h0000, 8'ha5);
        chk({18'h0, last_a}, 32'h0);
        chk({24'h0, mem[0]}, 32'ha5);
        xfer(8'h16, ssrp_pkg::ORDER_ADDR, 8'h00);
        xfer(8'h0a, 14'h0000, 8'h00);
        chk(rx, 32'ha5);
        $display("burst wrap done");
        // Pair interrupted by another access, then cleared by soft reset
        xfer(8'h00, 14'h003c, 8'h11);
        xfer(8'h00, 14'h0050, 8'h22);
        chk({23'h0, mra, mem[8'h3c]}, 32'h100);
        xfer(8'h02, ssrp_pkg::ABORT_ADDR, 8'h00);
        chk(rx, 32'h1);
        xfer(8'h00, ssrp_pkg::MASTER_CONFIG_ONE_ADDR, 8'h80);
        chk({30'h0, soft_rst, mra}, 32'h2);
        xfer(8'h00, ssrp_pkg::MASTER_CONFIG_ONE_ADDR, 8'h00);
        wb(1'h1, ssrp_pkg::HR_CTRL, 32'h80);
        hold_off();
        xfer(8'h00, 14'h003c, 8'h33);
        xfer(8'h00, 14'h003d, 8'h44);
        chk({16'h0, mem[8'h3d], mem[8'h3c]}, 32'h4433);
        $display("pair and soft reset done");
        // Host reset in mid data byte lifts select early
        wsave = wcnt;
        start(8'h00, 14'h0066, 8'h77);
        repeat (170) @(posedge clk_i);
        rst_h <= 1'h1;
        @(posedge clk_i);
        rst_h <= 1'h0;
        hold_off();
        chk(32'(wcnt), 32'(wsave));
        xfer(8'h00, 14'h0066, 8'h78);
        chk({24'h0, mem[8'h66]}, 32'h78);
        $display("early end done");
        finish_test();
    end
    // Whole run needs about 0.8 ms; this cuts a hang short
    initial begin
        #3000000;
        miscompares++;
        finish_test();
    end
endmodule : testbench
`default_nettype wire
